/* File: logic/ecc_cfg.svh */
// ecc_cfg.svh: field positions, reset values and encodings for the
// external cache control and dcache status logic.
// assumes inclusion by bare name from the package only; the main module relies on its macros.
`ifndef ECC_CFG_SVH
`define ECC_CFG_SVH

// external_cache_control field positions (64-bit write-only register)
`define ECC_CTL_ENA_BIT       0
`define ECC_CTL_CHK_MODE_BIT  1
`define ECC_CTL_TCP_INJ_BIT   2
`define ECC_CTL_DP_INJ_BIT    3
`define ECC_CTL_SIZE_LSB      4
`define ECC_CTL_SIZE_MSB      6
`define ECC_CTL_QDIS_LSB      32
`define ECC_CTL_QDIS_MSB      35

// control reset values; size code and quadrant field are left undefined by
// hardware, so they reset to plain values
`define ECC_CTL_ENA_RST       1'h0
`define ECC_CTL_CHK_RST       1'h0
`define ECC_CTL_TCP_RST       1'h0
`define ECC_CTL_DP_RST        1'h0
`define ECC_CTL_SIZE_RST      3'h0
`define ECC_CTL_QDIS_RST      4'h0

// dcache_status field positions
`define ECC_ST_HIT_BIT        0
`define ECC_ST_SEO_BIT        1
`define ECC_ST_INT_BIT        2
`define ECC_ST_LW_BIT         3
`define ECC_ST_LFLT_BIT       4
`define ECC_ST_LOCK_BIT       5
`define ECC_ST_STORE_BIT      6
`define ECC_ST_RA_LSB         7
`define ECC_ST_RA_MSB         11

// check-bit positions flipped by data check injection
`define ECC_DP_INJ_MASK       28'h0204081

// smallest cache size in KB; each code step up to code 6 doubles it
`define ECC_SIZE_BASE_KB      14'h0080
`define ECC_SIZE_MAX_CODE     3'h6

`endif

/* File: logic/ecc_pkg.sv */
// ecc_pkg.sv: types shared by the external cache control logic.
// assumes ecc_cfg.svh sits on the include path.
package ecc_pkg;
  `include "ecc_cfg.svh"

  typedef enum logic [1:0] {
    ECC_IDLE,
    ECC_PROBE,
    ECC_BYPASS
  } ecc_route_t;

  typedef enum logic {
    ECC_MODE_PARITY,
    ECC_MODE_ECC
  } ecc_chk_mode_t;
endpackage : ecc_pkg

/* File: logic/ecc_status_lock.sv */
// ecc_status_lock.sv: lockable dcache status word with second-error flag.
// assumes the caller supplies same-clock single-cycle event pulses.
`timescale 1ns/10ps
module ecc_status_lock
  import ecc_pkg::*;
(
  input  wire logic        mclk,         // cpu clock
  input  wire logic        rst,          // async reset, active high
  input  wire logic        access_done,  // a load or store finished
  input  wire logic        access_hit,   // it hit the dcache
  input  wire logic        fill_err,     // fill ecc or parity error
  input  wire logic [4:0]  err_ra,       // faulting register specifier
  input  wire logic        err_int,      // integer access
  input  wire logic        err_lw,       // longword length
  input  wire logic        err_lflt,     // legacy float format
  input  wire logic        err_lock,     // locked load / conditional store
  input  wire logic        err_store,    // store access
  input  wire logic        unlock_rd,    // read of unlock pseudo-register
  output logic             locked,       // status is locked
  output logic [11:0]      status        // packed status word
);

  logic        lock_ff;
  logic        hit_ff;
  logic        seo_ff;
  logic [9:0]  attr_ff;
  logic        nxt_lock;
  logic        nxt_hit;
  logic        nxt_seo;
  logic [9:0]  nxt_attr;
  wire  logic       take_err;
  wire  logic [9:0] err_attr;

  ////////////////////////////////////////////////////////////////////////
  assign take_err = fill_err && !lock_ff;
  assign err_attr = {err_ra, err_store, err_lock, err_lflt && !err_int,
                     err_lw, err_int};                             // [R15]

  // error wins over a same-cycle unlock so no fault is lost
  assign nxt_lock = fill_err ? 1'h1 : (unlock_rd ? 1'h0 : lock_ff); // [R9] [R10]
  assign nxt_hit  = (access_done && !lock_ff) ? access_hit : hit_ff; // [R11]
  assign nxt_seo  = (fill_err && lock_ff) ? 1'h1 :
                    (unlock_rd ? 1'h0 : seo_ff);                    // [R12]
  assign nxt_attr = take_err ? err_attr : attr_ff;                  // [R14] [R19]

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lock_ff <= 1'h0;
      hit_ff  <= 1'h0;
      seo_ff  <= 1'h0;
      attr_ff <= 10'h000;
    end else begin
      lock_ff <= nxt_lock;
      hit_ff  <= nxt_hit;
      seo_ff  <= nxt_seo;
      attr_ff <= nxt_attr;
    end
  end

  assign locked = lock_ff;
  assign status = {attr_ff[9:5], attr_ff[4], attr_ff[3], attr_ff[2], attr_ff[1],
                   attr_ff[0], seo_ff, hit_ff};

  ////////////////////////////////////////////////////////////////////////
  AST_LOCK_SETS: assert property (@(posedge mclk) disable iff (rst)
    fill_err |=> lock_ff) else $error("lock not set after fill error"); // [R9]
  AST_UNLOCK: assert property (@(posedge mclk) disable iff (rst)
    unlock_rd && !fill_err |=> !lock_ff) else $error("unlock read ignored"); // [R10]
  AST_SEO: assert property (@(posedge mclk) disable iff (rst)
    fill_err && lock_ff |=> seo_ff) else $error("second error missed"); // [R12]
  AST_HOLD_ATTR: assert property (@(posedge mclk) disable iff (rst)
    lock_ff && !unlock_rd |=> $stable(attr_ff)) else $error("attrs moved while locked"); // [R19]
  AST_CAPTURE_RA: assert property (@(posedge mclk) disable iff (rst)
    take_err |=> attr_ff[9:5] == $past(err_ra)) else $error("ra not captured"); // [R14]
  AST_LFLT: assert property (@(posedge mclk) disable iff (rst)
    attr_ff[0] |-> !attr_ff[2]) else $error("float flag with int flag"); // [R15]
  COV_LOCK_UNLOCK: cover property (@(posedge mclk) disable iff (rst)
    fill_err ##[1:20] unlock_rd);
  COV_SECOND: cover property (@(posedge mclk) disable iff (rst) fill_err && lock_ff);
endmodule : ecc_status_lock

/* File: logic/ecc_ctl_status.sv */
// ecc_ctl_status.sv: external cache control register, reference routing,
// write-side error injection and the lockable dcache status register.
// assumes a privileged register-move port with same-clock strobes and
// same-clock event pulses from the load/store and fill pipelines.
//
// Overview of operation
// R1 - tag control injection corrupts every fast write parity
// R2 - four-bit field disables cache per quadrant
// R3 - enable, quadrant bits, address 33:32 pick cache use
// R4 - bypassed references skip probe, request bus immediately
// R5 - quadrant field never affects primary cacheability
// R6 - software must write quadrant field after reset
// R7 - data injection inverts check bits 0,7,14,21
// R8 - size code decodes 128 KB up to 8 MB
// R9 - fill ecc or parity error locks status
// R10 - reading unlock pseudo-register releases the lock
// R11 - hit flag reports last load or store while unlocked
// R12 - error while locked sets second-error flag
// R13 - error modifiers valid only with fill error flags
// R14 - capture faulting register specifier on lock
// R15 - record integer, longword and legacy float attributes
// R16 - lock flag for locked loads, conditional stores
// R17 - store flag for faulting store accesses
// R18 - check-mode bit selects ecc or parity
// R19 - attributes loaded with lock, held until unlock
`timescale 1ns/10ps
module ecc_ctl_status
  import ecc_pkg::*;
(
  input  wire logic        mclk,            // cpu clock, 100 MHz
  input  wire logic        rst,             // async reset, active high
  // privileged register moves
  input  wire logic        ctl_wr,          // write external_cache_control
  input  wire logic [63:0] ctl_wdata,       // write data
  input  wire logic        stat_rd,         // read dcache_status
  input  wire logic        unlock_rd,       // read dcache_unlock_pseudo_reg
  output logic [63:0]      rdata,           // read data, registered
  output logic             rvalid,          // read data valid pulse
  // reference routing
  input  wire logic        ref_valid,       // read or write reference
  input  wire logic [33:0] ref_pa,          // physical address
  output logic             probe_req,       // probe the tag store
  output logic             bus_req,         // direct system bus request
  output logic             primary_cacheable, // from read-ack, not quadrant bits
  input  wire logic        read_ack_field,  // cacheable indication from bus
  // write-side injection, check mode and cache size
  input  wire logic        fast_wr,         // fast external cache RAM write
  input  wire logic        tag_ctl_par,     // tag control parity as computed
  output logic             tag_ctl_par_out, // parity driven to RAM
  input  wire logic        offchip_wr,      // off-chip write cycle
  input  wire logic [27:0] check_in,        // check bits as computed
  output logic [27:0]      check_out,       // check bits driven out
  output logic             chk_ecc_mode,    // 1 ecc, 0 parity
  output logic [13:0]      cache_size_kb,   // decoded cache size
  // status events
  input  wire logic        access_done,     // load or store finished
  input  wire logic        access_hit,      // it hit
  input  wire logic        fill_ecc,        // fill ecc error
  input  wire logic        fill_parity_error, // fill parity error
  input  wire logic [4:0]  fault_reg_number, // register specifier
  input  wire logic        op_int,          // integer access
  input  wire logic        op_longword,     // longword length
  input  wire logic        op_legacy_float, // legacy float format
  input  wire logic        load_locked_long, // locked load, longword
  input  wire logic        load_locked_quad, // locked load, quadword
  input  wire logic        store_cond_long, // conditional store, longword
  input  wire logic        store_cond_quad, // conditional store, quadword
  input  wire logic        op_store,        // store access
  output logic             status_locked    // status lock state
);

  ////////////////////////////////////////////////////////////////////////
  // control register
  logic        ena_ff;
  logic        chk_ff;
  logic        tcp_inj_ff;
  logic        dp_inj_ff;
  logic [2:0]  size_ff;
  logic [3:0]  qdis_ff;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ena_ff     <= `ECC_CTL_ENA_RST;
      chk_ff     <= `ECC_CTL_CHK_RST;
      tcp_inj_ff <= `ECC_CTL_TCP_RST;                               // [R1]
      dp_inj_ff  <= `ECC_CTL_DP_RST;
      size_ff    <= `ECC_CTL_SIZE_RST;
      qdis_ff    <= `ECC_CTL_QDIS_RST;                              // [R6]
    end else if (ctl_wr) begin
      ena_ff     <= ctl_wdata[`ECC_CTL_ENA_BIT];
      chk_ff     <= ctl_wdata[`ECC_CTL_CHK_MODE_BIT];               // [R18]
      tcp_inj_ff <= ctl_wdata[`ECC_CTL_TCP_INJ_BIT];
      dp_inj_ff  <= ctl_wdata[`ECC_CTL_DP_INJ_BIT];
      size_ff    <= ctl_wdata[`ECC_CTL_SIZE_MSB:`ECC_CTL_SIZE_LSB];
      qdis_ff    <= ctl_wdata[`ECC_CTL_QDIS_MSB:`ECC_CTL_QDIS_LSB]; // [R2]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reference routing
  wire logic use_cache;
  wire logic qdis_hit;
  ecc_route_t nxt_route;
  logic       probe_ff;
  logic       bus_ff;
  logic       pcache_ff;

  assign qdis_hit  = qdis_ff[ref_pa[33:32]];                        // [R3]
  assign use_cache = ena_ff && !qdis_hit;                           // [R3]
  assign nxt_route = !ref_valid ? ECC_IDLE :
                     (use_cache ? ECC_PROBE : ECC_BYPASS);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      probe_ff  <= 1'h0;
      bus_ff    <= 1'h0;
      pcache_ff <= 1'h0;
    end else begin
      probe_ff  <= (nxt_route == ECC_PROBE);
      bus_ff    <= (nxt_route == ECC_BYPASS);                       // [R4]
      pcache_ff <= read_ack_field;                                  // [R5]
    end
  end

  assign probe_req         = probe_ff;
  assign bus_req           = bus_ff;
  assign primary_cacheable = pcache_ff;

  ////////////////////////////////////////////////////////////////////////
  // write-side error injection, size decode and check mode; outputs registered, so one cycle behind
  logic        tcp_ff;
  logic [27:0] chk_out_ff;
  logic [13:0] size_kb_ff;
  logic        mode_ff;
  wire  logic [13:0] nxt_size_kb;

  // codes above the largest size clamp to the largest
  assign nxt_size_kb = (size_ff > `ECC_SIZE_MAX_CODE) ?
                       (`ECC_SIZE_BASE_KB << `ECC_SIZE_MAX_CODE) :
                       (`ECC_SIZE_BASE_KB << size_ff);              // [R8]

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tcp_ff     <= 1'h0;
      chk_out_ff <= 28'h0000000;
      size_kb_ff <= `ECC_SIZE_BASE_KB;
      mode_ff    <= 1'h0;
    end else begin
      tcp_ff     <= tag_ctl_par ^ (fast_wr && tcp_inj_ff);          // [R1]
      chk_out_ff <= (offchip_wr && dp_inj_ff) ?
                    (check_in ^ `ECC_DP_INJ_MASK) : check_in;       // [R7]
      size_kb_ff <= nxt_size_kb;
      mode_ff    <= chk_ff;                                         // [R18]
    end
  end

  assign tag_ctl_par_out = tcp_ff;
  assign check_out       = chk_out_ff;
  assign cache_size_kb   = size_kb_ff;
  assign chk_ecc_mode    = mode_ff;

  ////////////////////////////////////////////////////////////////////////
  // dcache status
  wire logic        fill_err;
  wire logic        lock_op;
  wire logic        locked_w;
  wire logic [11:0] status_w;
  logic             lock_q_ff;
  logic [63:0]      rdata_ff;
  logic             rvalid_ff;

  assign fill_err = fill_ecc || fill_parity_error;                  // [R9]
  assign lock_op  = load_locked_long || load_locked_quad ||
                    store_cond_long || store_cond_quad;             // [R16]

  ecc_status_lock u_stat (
    .mclk        (mclk),
    .rst         (rst),
    .access_done (access_done),
    .access_hit  (access_hit),
    .fill_err    (fill_err),
    .err_ra      (fault_reg_number),
    .err_int     (op_int),
    .err_lw      (op_longword),
    .err_lflt    (op_legacy_float),
    .err_lock    (lock_op),                                         // [R16]
    .err_store   (op_store),                                        // [R17]
    .unlock_rd   (unlock_rd),                                       // [R10]
    .locked      (locked_w),
    .status      (status_w)
  );

  // modifiers only meaningful while the lock (mirroring the fill error
  // flags) stands, so they read as zero otherwise
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_ff  <= 64'h0;
      rvalid_ff <= 1'h0;
      lock_q_ff <= 1'h0;
    end else begin
      rvalid_ff <= stat_rd || unlock_rd;
      lock_q_ff <= locked_w;
      if (stat_rd) begin
        rdata_ff <= {52'h0, (locked_w ? status_w[11:2] : 10'h000),
                     status_w[1:0]};                                // [R13] [R11]
      end else begin
        rdata_ff <= 64'h0;
      end
    end
  end

  assign rdata         = rdata_ff;
  assign rvalid        = rvalid_ff;
  assign status_locked = lock_q_ff;

  ////////////////////////////////////////////////////////////////////////
  AST_BYPASS: assert property (@(posedge mclk) disable iff (rst)
    ref_valid && !use_cache |=> bus_req && !probe_req)
    else $error("bypassed reference probed");                       // [R4]
  AST_QUAD: assert property (@(posedge mclk) disable iff (rst)
    ref_valid && qdis_ff[ref_pa[33:32]] |=> !probe_req)
    else $error("disabled quadrant probed");                        // [R3]
  AST_TCP: assert property (@(posedge mclk) disable iff (rst)
    fast_wr && tcp_inj_ff |=> tag_ctl_par_out != $past(tag_ctl_par))
    else $error("tag parity not corrupted");                        // [R1]
  AST_DP: assert property (@(posedge mclk) disable iff (rst)
    offchip_wr && dp_inj_ff |=> (check_out ^ $past(check_in)) == 28'h0204081)
    else $error("check bits not inverted");                         // [R7]
  AST_MOD_ZERO: assert property (@(posedge mclk) disable iff (rst)
    stat_rd && !locked_w |=> rdata[11:2] == 10'h000)
    else $error("modifiers shown without error");                   // [R13]
  AST_SIZE: assert property (@(posedge mclk) disable iff (rst)
    size_ff == 3'h3 ##1 size_ff == 3'h3 |-> cache_size_kb == 14'h0400)
    else $error("size decode wrong");                               // [R8]
  COV_BYPASS: cover property (@(posedge mclk) disable iff (rst) bus_req);
  COV_INJECT: cover property (@(posedge mclk) disable iff (rst) offchip_wr && dp_inj_ff);
  COV_RD_LOCKED: cover property (@(posedge mclk) disable iff (rst) stat_rd && locked_w);
endmodule : ecc_ctl_status

/* File: verif/ecc_far_model.sv */
// ecc_far_model.sv: behavioural far side, external cache rams and system bus.
// assumes registered single-cycle request pulses from the block.
`timescale 1ns/10ps
module ecc_far_model (
  input  wire logic mclk,          // cpu clock
  input  wire logic rst,           // async reset, active high
  input  wire logic probe_req,     // tag probe request
  input  wire logic bus_req,       // direct system bus request
  input  wire logic cacheable_sel, // bench picks the next answer
  output logic      read_ack_field // cacheable indication
);
  // primary cacheability comes from here, never from the quadrant field
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      read_ack_field <= 1'h0;
    end else if (probe_req || bus_req) begin
      read_ack_field <= cacheable_sel;
    end
  end
endmodule : ecc_far_model

/* File: verif/ext_cache_ctl_and_fill_error_status_tb_top.sv */
// ext_cache_ctl_and_fill_error_status_tb_top.sv: self-checking bench.
// assumes the design's registered one-cycle answers and ecc_far_model.
`timescale 1ns/10ps
module ext_cache_ctl_and_fill_error_status_tb_top;
  import ecc_pkg::*;
  typedef struct packed {logic [63:0] ctl; logic [1:0] q; logic probe;} ecc_row_t;
  logic        mclk, rst, ctl_wr, stat_rd, unlock_rd, ref_valid, fast_wr, tag_ctl_par;
  logic        offchip_wr, access_done, access_hit, fill_ecc, fill_par, cacheable_sel;
  logic [63:0] ctl_wdata, rdata;
  logic [33:0] ref_pa;
  logic [27:0] check_in, check_out;
  logic [13:0] cache_size_kb;
  logic [4:0]  ra;
  logic [7:0]  at;
  logic        rvalid, probe_req, bus_req, prim_c, rack, tcp_out, ecc_mode, locked;
  int          fail_count, check_count;
  ecc_row_t    rows [7];

  ecc_ctl_status DUT (.mclk(mclk), .rst(rst), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
    .stat_rd(stat_rd), .unlock_rd(unlock_rd), .rdata(rdata), .rvalid(rvalid),
    .ref_valid(ref_valid), .ref_pa(ref_pa), .probe_req(probe_req), .bus_req(bus_req),
    .primary_cacheable(prim_c), .read_ack_field(rack), .fast_wr(fast_wr),
    .tag_ctl_par(tag_ctl_par), .tag_ctl_par_out(tcp_out), .offchip_wr(offchip_wr),
    .check_in(check_in), .check_out(check_out), .chk_ecc_mode(ecc_mode),
    .cache_size_kb(cache_size_kb), .access_done(access_done), .access_hit(access_hit),
    .fill_ecc(fill_ecc), .fill_parity_error(fill_par), .fault_reg_number(ra),
    .op_int(at[0]), .op_longword(at[1]), .op_legacy_float(at[2]),
    .load_locked_long(at[3]), .load_locked_quad(at[4]), .store_cond_long(at[5]),
    .store_cond_quad(at[6]), .op_store(at[7]), .status_locked(locked));
  ecc_far_model far (.mclk(mclk), .rst(rst), .probe_req(probe_req), .bus_req(bus_req),
    .cacheable_sel(cacheable_sel), .read_ack_field(rack));

  always #5 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(); @(posedge mclk); #1; endtask : tick
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr_ctl(input logic [63:0] d);
    ctl_wr = 1; ctl_wdata = d; tick(); ctl_wr = 0; tick();
  endtask : wr_ctl
  task automatic rd(input logic unl, output logic [63:0] d);
    stat_rd = !unl; unlock_rd = unl; tick(); stat_rd = 0; unlock_rd = 0;
    chk("rvalid", 1, rvalid); d = rdata;
  endtask : rd
  task automatic ref_go(input logic [1:0] q);
    ref_pa = {q, 32'h0000_1040}; ref_valid = 1; tick(); ref_valid = 0;
  endtask : ref_go
  task automatic fill_err(input logic ecc, input logic [4:0] r, input logic [7:0] a);
    fill_ecc = ecc; fill_par = !ecc; ra = r; at = a; tick();
    fill_ecc = 0; fill_par = 0; at = 8'h00; ra = 5'h00;
  endtask : fill_err
  task automatic wait_lock(input logic v);
    for (int i = 0; i < 4 && locked !== v; i++) tick();
    chk("status_locked", v, locked);
  endtask : wait_lock
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  initial begin
    #100000;
    fail_count++;
    end_sim();
  end

  initial begin
    logic [63:0] d;
    {mclk, ctl_wr, stat_rd, unlock_rd, ref_valid, fast_wr, tag_ctl_par} = '0;
    {offchip_wr, access_done, access_hit, fill_ecc, fill_par, cacheable_sel} = '0;
    {ctl_wdata, ref_pa, check_in, ra, at} = '0;
    fail_count = 0; check_count = 0;
    rows = '{'{64'h1, 2'h0, 1}, '{64'h1, 2'h3, 1}, '{64'h0, 2'h1, 0},
             '{64'h5_0000_0001, 2'h0, 0}, '{64'h5_0000_0001, 2'h1, 1},
             '{64'h5_0000_0001, 2'h2, 0}, '{64'h5_0000_0001, 2'h3, 1}};
    rst = 1; repeat (3) @(posedge mclk); #1; rst = 0;
    chk("size_after_reset", 64'd128, cache_size_kb);
    chk("locked_after_reset", 0, locked);
    wr_ctl(64'h1); // quadrant field written before use
    foreach (rows[i]) begin
      wr_ctl(rows[i].ctl);
      ref_go(rows[i].q);
      chk("probe_req", rows[i].probe, probe_req);
      chk("bus_req", !rows[i].probe, bus_req);
      tick();
      chk("req_drop", 0, probe_req | bus_req);
    end
    // all quadrants off, yet the far side still makes it cacheable
    wr_ctl(64'hf_0000_0001); cacheable_sel = 1; ref_go(2'h2);
    chk("bus_req_off", 1, bus_req);
    tick(); tick(); chk("prim_cacheable", 1, prim_c);
    wr_ctl(64'h1); cacheable_sel = 0; ref_go(2'h2); tick(); tick();
    chk("prim_uncacheable", 0, prim_c);
    for (int c = 0; c < 8; c++) begin
      wr_ctl(64'(c) << 4); tick();
      chk("cache_size_kb", (c == 7) ? 64'd8192 : (64'd128 << c), cache_size_kb);
    end
    for (int inj = 0; inj < 2; inj++) begin
      wr_ctl(inj ? 64'he : 64'h0); tick();
      chk("ecc_mode", inj, ecc_mode);
      fast_wr = 1; tag_ctl_par = 0; offchip_wr = 1; check_in = 28'h0aaaaaa; tick();
      chk("tag_par", inj, tcp_out);
      chk("check_out", 28'h0aaaaaa ^ (inj ? 28'h0204081 : 28'h0), check_out);
      fast_wr = 0; offchip_wr = 0; tick();
      chk("tag_par_idle", 0, tcp_out);
    end
    access_done = 1; access_hit = 1; tick(); access_done = 0; tick();
    rd(0, d); chk("hit_set", 64'h1, d);
    access_done = 1; access_hit = 0; tick(); access_done = 0; tick();
    rd(0, d); chk("hit_clear", 64'h0, d);
    // integer longword locked load: float flag suppressed
    fill_err(1, 5'h15, 8'h17); wait_lock(1);
    rd(0, d); chk("stat_lock1", 64'haac, d);
    access_done = 1; access_hit = 1; tick(); access_done = 0;
    fill_err(0, 5'h02, 8'h80); tick(); tick();
    rd(0, d); chk("stat_second", 64'haae, d);
    rd(1, d); chk("unlock_data", 64'h0, d);
    wait_lock(0);
    rd(0, d); chk("stat_unlocked", 64'h0, d);
    // float store-conditional store by a non-integer op
    fill_err(0, 5'h03, 8'ha4); wait_lock(1);
    rd(0, d); chk("stat_lock2", 64'h1f0, d);
    rd(1, d); wait_lock(0);
    end_sim();
  end
endmodule : ext_cache_ctl_and_fill_error_status_tb_top
